// >>> bench/rmc_modem.sv
// Partner model of the modem that faces the modem control block.
// Assumes it shares the block's clock; CTS answers RTS after delay_in cycles.
`timescale 1ns/100ps
module rmc_modem (
   input  wire logic       clk_in,   // System clock.
   input  wire logic       rts_in,   // Request to send from the block.
   input  wire logic [3:0] delay_in, // Cycles before CTS is granted.
   input  wire logic       dcd_in,   // Carrier level commanded by the bench.
   output logic            cts_out,  // Clear to send towards the block.
   output logic            dcd_out   // Carrier detect towards the block.
);
   logic [3:0] cnt_r = 4'h0; // Cycles that RTS has stood high.
   // Grant CTS only once RTS has stood long enough; drop it with RTS.
   always @(posedge clk_in) begin
      cnt_r   <= rts_in ? ((cnt_r == 4'hf) ? cnt_r : cnt_r + 4'h1) : 4'h0;
      cts_out <= rts_in && (cnt_r >= delay_in);
      dcd_out <= dcd_in;
   end
endmodule

// >>> bench/tb.sv
// Self-checking bench of the modem control block with a modem model.
// Assumes the package constants and the hand-over timing of the block.
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
   $display("MISMATCH %s exp=%h got=%h", n, e, g); end end
module tb;
   import rmc_pkg::*;
   logic clk_in = 1'b0, sys_rst_in = 1'b1, cfg_load_in = 1'b0, tx_pending_in = 1'b0;
   logic tx_busy_in = 1'b0, rx_ack_in = 1'b0, dcd_cmd = 1'b0, tx_allow, rts, cts, dcd;
   logic dcd_ev, cts_ev, rx_irq;
   logic [3:0] delay = 4'h3;           // Modem answer delay.
   rmc_cfg_t cfg_in = '0, cfg_out, c;  // Configuration in, out and scratch.
   rmc_byte_t rx_byte_in = '0, rx_store;
   int fail_count = 0, n_compared = 0, dcd_n = 0, cts_n = 0, i, k, j;
   rmc_hs_mode_t modes [5] = '{RMC_HS_OFF, RMC_HS_ON, RMC_HS_MANUAL, RMC_HS_AUTO, RMC_HS_RTSCTS};
   rmc_ctrl DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .cfg_load_in(cfg_load_in),
      .cfg_in(cfg_in), .tx_pending_in(tx_pending_in), .tx_busy_in(tx_busy_in),
      .tx_allow_out(tx_allow), .rx_byte_in(rx_byte_in), .rx_ack_in(rx_ack_in),
      .rx_store_out(rx_store), .rx_irq_out(rx_irq), .cts_pin_in(cts), .dcd_pin_in(dcd),
      .rts_pin_out(rts), .carrier_detect_change_event_out(dcd_ev),
      .cts_change_event_out(cts_ev), .cfg_out(cfg_out));
   rmc_modem u_modem (.clk_in(clk_in), .rts_in(rts), .delay_in(delay), .dcd_in(dcd_cmd),
      .cts_out(cts), .dcd_out(dcd));
   // Clock of 5 ns period.
   initial forever #2.5 clk_in = ~clk_in;
   // Count event pulses seen on each rising clock edge.
   always @(posedge clk_in) begin
      dcd_n += (dcd_ev === 1'b1);
      cts_n += (cts_ev === 1'b1);
   end
   // Default configuration with a chosen mode and manual level.
   function automatic rmc_cfg_t cfg_of(rmc_hs_mode_t m, logic man);
      cfg_of = '{m, man, 2'h2, 1'b0, 1'b1, 1'b1};
   endfunction
   // Expected RTS level for a mode and transmit activity.
   function automatic logic exp_rts(rmc_cfg_t x, logic act);
      exp_rts = (x.hs_mode == RMC_HS_OFF) ? 1'b0 : (x.hs_mode == RMC_HS_ON) ? 1'b1 :
                (x.hs_mode == RMC_HS_MANUAL) ? x.manual_rts : act;
   endfunction
   task automatic tick(int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   // Load a configuration and wait for RTS to follow.
   task automatic load(rmc_cfg_t x);
      @(posedge clk_in) cfg_load_in <= 1'b1;
      cfg_in <= x;
      @(posedge clk_in) cfg_load_in <= 1'b0;
      tick(2);
      `CHK("cfg", x, cfg_out)
   endtask
   // Send one byte and check what the block keeps.
   task automatic send(logic [7:0] d, logic v);
      @(posedge clk_in) rx_byte_in <= '{1'b1, d};
      @(posedge clk_in) rx_byte_in <= '0;
      #1;
      `CHK("store", v ? {1'b1, d} : 9'h000, {rx_store.valid, v ? rx_store.data : 8'h00})
   endtask
   task automatic ack();
      @(posedge clk_in) rx_ack_in <= 1'b1;
      @(posedge clk_in) rx_ack_in <= 1'b0;
      tick(1);
      `CHK("irq_clr", 1'b0, rx_irq)
   endtask
   task automatic stop_test();
      if (fail_count == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Watchdog against a hung run.
   initial begin
      repeat (20000) @(posedge clk_in);
      fail_count++;
      stop_test();
   end
   initial begin
      void'($urandom(47));
      tick(20);
      `CHK("rst_cfg", cfg_of(RMC_HS_OFF, 1'b0), cfg_out)
      `CHK("rst_rts", 1'b0, rts)
      @(posedge clk_in) sys_rst_in <= 1'b0;
      // Every mode with and without transmit activity.
      for (i = 0; i < 10; i++) begin
         c = cfg_of(modes[i / 2], 1'($urandom));
         @(posedge clk_in) tx_busy_in <= 1'(i % 2);
         load(c);
         `CHK("rts_mode", exp_rts(c, 1'(i % 2)), rts)
      end
      @(posedge clk_in) tx_busy_in <= 1'b0;
      // Handshake: RTS first, send only after CTS, RTS drops after the end.
      delay <= 4'($urandom_range(2, 9));
      load(cfg_of(RMC_HS_RTSCTS, 1'b0));
      @(posedge clk_in) tx_pending_in <= 1'b1;
      tick(2);
      `CHK("rts_req", 1'b1, rts)
      `CHK("allow_wait", 1'b0, tx_allow)
      for (j = 0; j < 40 && tx_allow !== 1'b1; j++) tick(1);
      `CHK("allow_go", 1'b1, tx_allow)
      @(posedge clk_in) tx_pending_in <= 1'b0;
      tx_busy_in <= 1'b1;
      tick(3);
      `CHK("rts_busy", 1'b1, rts)
      @(posedge clk_in) tx_busy_in <= 1'b0;
      tick(2);
      `CHK("rts_end", 1'b0, rts)
      // Discard while sending, keep while idle.
      c = cfg_of(RMC_HS_OFF, 1'b0);
      c.discard_en = 1'b1;
      load(c);
      @(posedge clk_in) tx_busy_in <= 1'b1;
      send(8'($urandom), 1'b0);
      @(posedge clk_in) tx_busy_in <= 1'b0;
      send(8'($urandom), 1'b1);
      ack();
      // Every threshold: interrupt exactly at the count.
      for (k = 0; k < 4; k++) begin
         c = cfg_of(RMC_HS_OFF, 1'b0);
         c.thr_sel = 2'(k);
         load(c);
         for (j = 0; j < ((k == 0) ? 1 : (k == 1) ? 4 : (k == 2) ? 8 : 14); j++) begin
            `CHK("irq_low", 1'b0, rx_irq)
            send(8'($urandom), 1'b1);
         end
         `CHK("irq_high", 1'b1, rx_irq)
         ack();
      end
      // Both edges of DCD and CTS, with events enabled then disabled.
      for (k = 1; k >= 0; k--) begin
         c = cfg_of(RMC_HS_OFF, 1'b0);
         c.dcd_ev_en = 1'(k);
         c.cts_ev_en = 1'(k);
         load(c);
         dcd_n = 0;
         cts_n = 0;
         for (j = 0; j < 2; j++) begin
            @(posedge clk_in) dcd_cmd <= ~dcd_cmd;
            c.hs_mode = j ? RMC_HS_OFF : RMC_HS_ON;
            load(c);
            tick(20);
         end
         `CHK("dcd_ev", 2 * k, dcd_n)
         `CHK("cts_ev", 2 * k, cts_n)
      end
      stop_test();
   end
endmodule

// >>> hw/rmc_ctrl.sv
// Modem control logic: RTS handshake, receive threshold, discard and line events.
// Assumes the UART core supplies transmit pending/busy levels and a received byte strobe.
`timescale 1ns/100ps
module rmc_ctrl
   import rmc_pkg::*;
(
   input  wire logic       clk_in,                          // System clock, 200 MHz.
   input  wire logic       sys_rst_in,                      // Synchronous reset, active high.
   input  wire logic       cfg_load_in,                     // Pulse: take cfg_in.
   input  wire rmc_cfg_t   cfg_in,                          // New configuration.
   input  wire logic       tx_pending_in,                   // Characters wait to be sent.
   input  wire logic       tx_busy_in,                      // A character is on the line.
   output logic            tx_allow_out,                    // Transmitter may start.
   input  wire rmc_byte_t  rx_byte_in,                      // Received byte from the core.
   input  wire logic       rx_ack_in,                       // Pulse: software serviced bytes.
   output rmc_byte_t       rx_store_out,                    // Byte to keep, registered.
   output logic            rx_irq_out,                      // Threshold reached, level.
   input  wire logic       cts_pin_in,                      // Clear-to-send pin.
   input  wire logic       dcd_pin_in,                      // Carrier detect pin.
   output logic            rts_pin_out,                     // Request-to-send pin.
   output logic            carrier_detect_change_event_out, // Pulse on DCD change.
   output logic            cts_change_event_out,            // Pulse on CTS change.
   output rmc_cfg_t        cfg_out                          // Current configuration.
);

   // Configuration and state registers.
   rmc_cfg_t   cfg_r, cfg_nxt;               // Held configuration.
   logic [1:0] cts_sync_r, dcd_sync_r;       // Two-stage synchronisers.
   logic       cts_old_r, dcd_old_r;         // Previous synchronised levels.
   logic       rts_r, rts_nxt;               // Registered RTS.
   logic [3:0] rx_cnt_r, rx_cnt_nxt;         // Bytes stored since last service.
   logic       irq_r, irq_nxt;               // Interrupt level.
   rmc_byte_t  store_r, store_nxt;           // Byte forwarded for storage.
   logic       cd_ev_r, cts_ev_r;            // Event pulses.
   logic [3:0] thr_cnt;                      // Threshold as a byte count.
   logic       cts_s, dcd_s;                 // Synchronised pin levels.
   logic       tx_act;                       // Transmitter is active.

   assign cts_s  = cts_sync_r[1];
   assign dcd_s  = dcd_sync_r[1];
   assign tx_act = tx_pending_in | tx_busy_in;

   // Pins pass two flip-flops; the second stage alone feeds edge detection.
   always_ff @(posedge clk_in) begin
      cts_sync_r <= {cts_sync_r[0], cts_pin_in}; // RL11
      dcd_sync_r <= {dcd_sync_r[0], dcd_pin_in}; // RL11
   end

   // Configuration is loaded on a strobe and returns to defaults on reset.
   always_comb begin
      cfg_nxt = cfg_r;
      if (cfg_load_in) begin
         cfg_nxt = cfg_in;
      end
   end

   // Decode threshold select into a count.
   always_comb begin
      case (cfg_r.thr_sel)
         RMC_THR_SEL_1:  thr_cnt = RMC_THR_CNT_1;  // RL7
         RMC_THR_SEL_4:  thr_cnt = RMC_THR_CNT_4;
         RMC_THR_SEL_14: thr_cnt = RMC_THR_CNT_14;
         default:        thr_cnt = RMC_THR_CNT_8;
      endcase
   end

   // RTS next value from the handshake mode.
   always_comb begin
      case (cfg_r.hs_mode)
         RMC_HS_AUTO:   rts_nxt = tx_act;                // RL1
         RMC_HS_ON:     rts_nxt = 1'b1;                  // RL3
         RMC_HS_RTSCTS: rts_nxt = tx_act;                // RL4 RL5
         RMC_HS_MANUAL: rts_nxt = cfg_r.manual_rts;      // RL6
         default:       rts_nxt = 1'b0;                  // RL2
      endcase
   end

   // In RTS/CTS mode a new character waits for CTS; a started one finishes.
   assign tx_allow_out = (cfg_r.hs_mode != RMC_HS_RTSCTS) | cts_s; // RL5

   // Receive path: discard while sending, count kept bytes, raise interrupt.
   always_comb begin
      store_nxt  = '0;
      rx_cnt_nxt = rx_cnt_r;
      irq_nxt    = irq_r;
      if (rx_ack_in) begin
         rx_cnt_nxt = 4'h0;
         irq_nxt    = 1'b0;
      end
      if (rx_byte_in.valid && !(cfg_r.discard_en && tx_act)) begin // RL8
         store_nxt = rx_byte_in;
         // Saturate so the count never wraps past the largest threshold.
         if (rx_cnt_nxt != 4'hf) begin
            rx_cnt_nxt = rx_cnt_nxt + 4'h1;
         end
      end
      // A byte in the acknowledge cycle still counts, so set wins over clear.
      if (rx_cnt_nxt >= thr_cnt) begin
         irq_nxt = 1'b1; // RL7
      end
   end

   // Register all state but the synchronisers; reset loads defaults and drops RTS.
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         cfg_r.hs_mode    <= RMC_RST_HS_MODE;   // RL12
         cfg_r.manual_rts <= 1'b0;
         cfg_r.thr_sel    <= RMC_RST_THR_SEL;
         cfg_r.discard_en <= RMC_RST_DISCARD;
         cfg_r.dcd_ev_en  <= RMC_RST_DCD_EV;
         cfg_r.cts_ev_en  <= RMC_RST_CTS_EV;
         rts_r            <= 1'b0;              // RL12
         rx_cnt_r         <= 4'h0;
         irq_r            <= 1'b0;
         store_r          <= '0;
         cts_old_r        <= 1'b0;
         dcd_old_r        <= 1'b0;
         cd_ev_r          <= 1'b0;
         cts_ev_r         <= 1'b0;
      end else begin
         cfg_r     <= cfg_nxt;
         rts_r     <= rts_nxt;
         rx_cnt_r  <= rx_cnt_nxt;
         irq_r     <= irq_nxt;
         store_r   <= store_nxt;
         cts_old_r <= cts_s;
         dcd_old_r <= dcd_s;
         cd_ev_r   <= cfg_r.dcd_ev_en & (dcd_s ^ dcd_old_r); // RL9 RL11
         cts_ev_r  <= cfg_r.cts_ev_en & (cts_s ^ cts_old_r); // RL10 RL11
      end
   end

   assign rts_pin_out                     = rts_r;
   assign rx_irq_out                      = irq_r;
   assign rx_store_out                    = store_r;
   assign carrier_detect_change_event_out = cd_ev_r;
   assign cts_change_event_out            = cts_ev_r;
   assign cfg_out                         = cfg_r;

   // Checks beside the logic.
   // RTS lags the mode by one register, so the check looks at the mode one cycle back.

   // Off mode never lets RTS rise.
   a_rts_off_low: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL2
      $past(cfg_r.hs_mode) == RMC_HS_OFF |-> !rts_pin_out)
      else $error("RTS high in off mode");

   // On mode never lets RTS fall.
   a_rts_on_high: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL3
      $past(cfg_r.hs_mode) == RMC_HS_ON |-> rts_pin_out)
      else $error("RTS low in on mode");

   // Auto mode copies transmit activity one cycle later.
   a_rts_auto_follow: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL1
      cfg_r.hs_mode == RMC_HS_AUTO && cfg_nxt == cfg_r |=> rts_pin_out == $past(tx_act))
      else $error("RTS not following transmit in auto mode");

   // A pending send without CTS asks for permission.
   a_rts_req_cts: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL4
      cfg_r.hs_mode == RMC_HS_RTSCTS && !cfg_load_in && tx_pending_in && !cts_s
      |=> rts_pin_out)
      else $error("RTS not requested while waiting for CTS");

   // No new character starts while CTS is low.
   a_cts_gate_tx: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL5
      cfg_r.hs_mode == RMC_HS_RTSCTS && !cts_s |-> !tx_allow_out)
      else $error("Transmit allowed without CTS");

   // Manual mode shows only the software level.
   a_rts_manual: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL6
      cfg_r.hs_mode == RMC_HS_MANUAL && !cfg_load_in |=> rts_pin_out == $past(cfg_r.manual_rts))
      else $error("RTS not manual value");

   // A threshold change takes one cycle to reach the interrupt, so it is checked when stable.
   a_irq_thresh: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL7
      rx_cnt_r >= thr_cnt && $stable(cfg_r.thr_sel) |-> rx_irq_out)
      else $error("Threshold reached without interrupt");

   // A byte that arrives while sending is never stored when discarding is on.
   a_discard_tx: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL8
      cfg_r.discard_en && tx_act && rx_byte_in.valid |=> !rx_store_out.valid)
      else $error("Byte kept during transmit");

   // Each synchronised carrier change gives a pulse one cycle later.
   a_dcd_event: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL9
      cfg_r.dcd_ev_en && $changed(dcd_s) |=> carrier_detect_change_event_out)
      else $error("Missing carrier detect event");

   // Each synchronised CTS change gives a pulse one cycle later.
   a_cts_event: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL10
      cfg_r.cts_ev_en && $changed(cts_s) |=> cts_change_event_out)
      else $error("Missing CTS event");

   // The synchroniser is exactly two stages deep.
   a_sync_delay: assert property (@(posedge clk_in) disable iff (sys_rst_in) // RL11
      cts_s == $past(cts_pin_in, 2))
      else $error("CTS synchroniser depth wrong");

   // One edge of reset leaves RTS low and the default threshold.
   a_reset_dflt: assert property (@(posedge clk_in) // RL12
      sys_rst_in |=> !rts_pin_out && cfg_r.thr_sel == RMC_RST_THR_SEL)
      else $error("Reset defaults wrong");

   // Main scenarios that the bench is expected to reach.
   c_rtscts_send: cover property (@(posedge clk_in) disable iff (sys_rst_in)
      cfg_r.hs_mode == RMC_HS_RTSCTS && rts_pin_out ##1 cts_s && tx_busy_in);
   c_irq_raise: cover property (@(posedge clk_in) disable iff (sys_rst_in)
      !rx_irq_out ##1 rx_irq_out);
   c_discard: cover property (@(posedge clk_in) disable iff (sys_rst_in)
      cfg_r.discard_en && tx_act && rx_byte_in.valid);
   c_dcd_event: cover property (@(posedge clk_in) disable iff (sys_rst_in)
      carrier_detect_change_event_out);
   c_cts_event: cover property (@(posedge clk_in) disable iff (sys_rst_in)
      cts_change_event_out);

endmodule

// >>> hw/rmc_pkg.sv
// Package of constants and carriers for the RS-232 modem control block.
// Assumes a single 200 MHz system clock and a synchronous active-high reset.
// Behaviour
// RL1: Auto mode: RTS on during transmission only.
// RL2: RTS-off mode, the reset default, keeps RTS low.
// RL3: RTS-on mode keeps RTS high always.
// RL4: RTS/CTS mode: pending send raises RTS.
// RL5: RTS/CTS: wait for CTS, drop RTS after.
// RL6: Manual mode: RTS follows software value only.
// RL7: Receive interrupt at threshold 1, 4, 8, 14.
// RL8: Optionally drop bytes received while transmitting.
// RL9: DCD change raises event when enabled.
// RL10: CTS change raises event when enabled.
// RL11: Synchronise DCD, CTS; both edges count.
// RL12: Reset loads defaults and keeps RTS low.
package rmc_pkg;

   // Handshake modes, one-hot.
   typedef enum logic [4:0] {
      RMC_HS_OFF    = 5'h01,
      RMC_HS_AUTO   = 5'h02,
      RMC_HS_ON     = 5'h04,
      RMC_HS_RTSCTS = 5'h08,
      RMC_HS_MANUAL = 5'h10
   } rmc_hs_mode_t;

   // Threshold select codes.
   localparam logic [1:0] RMC_THR_SEL_1  = 2'h0;
   localparam logic [1:0] RMC_THR_SEL_4  = 2'h1;
   localparam logic [1:0] RMC_THR_SEL_8  = 2'h2;
   localparam logic [1:0] RMC_THR_SEL_14 = 2'h3;

   // Byte counts for each threshold code.
   localparam logic [3:0] RMC_THR_CNT_1  = 4'h1;
   localparam logic [3:0] RMC_THR_CNT_4  = 4'h4;
   localparam logic [3:0] RMC_THR_CNT_8  = 4'h8;
   localparam logic [3:0] RMC_THR_CNT_14 = 4'he;

   // Reset values of the configuration.
   localparam rmc_hs_mode_t RMC_RST_HS_MODE = RMC_HS_OFF;
   localparam logic [1:0]   RMC_RST_THR_SEL = RMC_THR_SEL_8;
   localparam logic         RMC_RST_DISCARD = 1'b0;
   localparam logic         RMC_RST_DCD_EV  = 1'b1;
   localparam logic         RMC_RST_CTS_EV  = 1'b1;

   // Configuration carried as one bundle.
   typedef struct packed {
      rmc_hs_mode_t hs_mode;       // Handshake mode.
      logic         manual_rts;    // Software RTS level for manual mode.
      logic [1:0]   thr_sel;       // Receive threshold select.
      logic         discard_en;    // Drop bytes received while sending.
      logic         dcd_ev_en;     // Enable carrier detect change event.
      logic         cts_ev_en;     // Enable clear-to-send change event.
   } rmc_cfg_t;

   // Received byte with its strobe.
   typedef struct packed {
      logic       valid;           // Byte present this cycle.
      logic [7:0] data;            // Byte value.
   } rmc_byte_t;

endpackage
